// ### flash_pin_map.svh
// Notes on behaviour
// RQ1 - In x16 mode the half-word select picks the upper or lower word half.
// RQ2 - In x32 mode the half-word select input is ignored.
// RQ3 - A 19-bit double word address reaches the whole 16 Mbit array.
// RQ4 - x32 mode drives all 32 data lines; x16 mode only the lower 16.
// RQ5 - Chip, output and write enables need no timing relation to the clock.
// RQ6 - All synchronous timing comes from the single device clock.
// RQ7 - Address load strobe low captures the pin address as the burst start.
// RQ8 - Last-word indicator goes low with the final word of finite bursts only.
// RQ9 - Wait output gives data-valid feedback only in continuous burst length.
// RQ10 - Write protect low refuses program of the two outermost boot sectors.
// RQ11 - Ready/busy is released high only when reads and commands are accepted.
// RQ12 - Ready/busy held low during embedded program or hardware reset.
// RQ13 - Acceleration input at high voltage shortens program operations.
// RQ14 - High voltage on the id address line selects identification reads.
// RQ15 - In x16 mode the upper 16 data lines never drive.
// RQ16 - Burst address advances one location per clock while output enable is low.
`ifndef FLASH_PIN_MAP_SVH
`define FLASH_PIN_MAP_SVH
`define CLK_PERIOD_NS 8
`define PROG_TIME_NS 2000
`define PROG_CYC ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_PROG_TIME_NS 400
`define ACC_PROG_CYC ((`ACC_PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HWRST_TIME_NS 500
`define HWRST_CYC ((`HWRST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFS_CTRL 8'h00
`define OFS_PADDR 8'h04
`define OFS_PDATA 8'h08
`define OFS_STATUS 8'h0C
`define CTRL_LEN_RST 2'h0
`define LEN_CONT 2'h0
`define LEN_4 2'h1
`define LEN_8 2'h2
`define LEN_32 2'h3
`define ST_BUSY 0
`define ST_REFUSED 1
`define ST_ACCEL 2
`define ST_IDSEL 3
`define ST_EMPTY 4
`define ST_FULL 5
`define PROT_BASE 19'h7F000
`define FIFO_DEPTH 32
`endif

// ### flash_pin_pkg.sv
package flash_pin_pkg;
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_prog = 3'h2,
        st_hwrst = 3'h4
    } prog_state_e;
    typedef logic [1:0] burst_len_t;
    typedef struct packed {
        logic valid;
        logic last;
        logic half;
        logic ident;
        logic id_dev;
    } beat_s;
endpackage

// ### prog_fifo.sv
`timescale 1ns/1ps
module prog_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic push;
    logic pop;

    assign in_ready = (wp_q - rp_q) != (AW+1)'(D);
    assign out_valid = wp_q != rp_q;
    assign out_data = mem[rp_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule

// ### flash_array.sv
`timescale 1ns/1ps
module flash_array #(
    parameter int AW = 19,
    parameter int DW = 32
) (
    input wire logic mclk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_q
);
    logic [DW-1:0] cells [2**AW];

    always_ff @(posedge mclk) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        rdata_q <= cells[raddr];
    end
endmodule

// ### burst_flash_pin_interface.sv
`timescale 1ns/1ps
`include "flash_pin_map.svh"
module burst_flash_pin_interface #(
    parameter logic [31:0] MAKER_ID = 32'h0000005A,
    parameter logic [31:0] DEVICE_ID = 32'h000000C3
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic hw_reset_n,
    input wire logic word_mode,
    input wire logic write_protect_n,
    input wire logic program_accelerate_input,
    input wire logic high_voltage_id_address_line,
    input wire logic [18:0] double_word_address_bus,
    input wire logic half_word_select,
    input wire logic burst_address_load_n,
    input wire logic [31:0] bidirectional_data_lines_i,
    output logic [31:0] bidirectional_data_lines_o,
    output logic [31:0] bidirectional_data_lines_oe,
    output logic burst_last_word_n,
    output logic wait_n,
    input wire logic ready_busy_n_i,
    output logic ready_busy_n_o,
    output logic ready_busy_n_oe
);
    // Identity values are arbitrary
    localparam int ACC_N = `ACC_PROG_CYC + 1;
    localparam int PROG_N = `PROG_CYC + 1;

    flash_pin_pkg::prog_state_e state_q, state_d;
    flash_pin_pkg::burst_len_t len_q;
    flash_pin_pkg::beat_s b0, pipe1_q;
    logic [11:0] cnt_q;
    logic [18:0] prog_addr_q;
    logic [31:0] pdata_q;
    logic refused_q;
    logic burst_q;
    logic [19:0] pos_q;
    logic [5:0] beat_q;
    logic [31:0] rdata;
    logic [31:0] dq_o_q;
    logic [31:0] dq_oe_q;
    logic last_n_q, wait_n_q, rb_oe_q, rb_o_q;
    logic dph_q, dwr_q, hreadyout_q, hresp_q;
    logic [7:0] dofs_q;
    logic [31:0] hrdata_q;
    logic acc, wr_done, fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic pop, prot_hit, mem_we;
    logic read_sel, load, advance, cont;
    logic [5:0] beats;
    logic [19:0] step, mask, nxt, pos_adv, start_unit;
    logic [6:0] units;
    logic last_beat;
    logic [18:0] raddr;
    logic [31:0] status;
    logic [31:0] rd_mux;

    // Control pins are plain levels; no edge of theirs clocks anything
    assign read_sel = !chip_enable_n && !output_enable_n && write_enable_n && hw_reset_n
        && state_q != flash_pin_pkg::st_hwrst; // RQ5
    assign load = !burst_address_load_n && !chip_enable_n && hw_reset_n;
    assign advance = burst_q && read_sel && burst_address_load_n;
    assign cont = len_q == `LEN_CONT;

    always_comb begin
        case (len_q)
            `LEN_4: beats = 6'h04;
            `LEN_8: beats = 6'h08;
            `LEN_32: beats = 6'h20;
            default: beats = 6'h00;
        endcase
        step = word_mode ? 20'h00002 : 20'h00001;
        units = word_mode ? {beats, 1'b0} : {1'b0, beats};
        mask = {13'h0000, units - 7'h01};
        nxt = pos_q + step;
        pos_adv = cont ? nxt : ((pos_q & ~mask) | (nxt & mask)); // RQ16
        last_beat = !cont && (beat_q == beats - 6'h01);
        // Half select joins the double word address only in x16 mode
        start_unit = {double_word_address_bus, half_word_select && !word_mode}; // RQ1 RQ2
    end

    // Burst start capture and linear/wrapping advance
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            burst_q <= 1'b0;
            pos_q <= '0;
            beat_q <= '0;
        end else if (!hw_reset_n || chip_enable_n) begin
            burst_q <= 1'b0;
        end else if (load) begin
            burst_q <= 1'b1;
            pos_q <= start_unit; // RQ7
            beat_q <= 6'h00;
        end else if (advance) begin
            pos_q <= pos_adv; // RQ16
            beat_q <= last_beat ? 6'h00 : beat_q + 6'h01;
        end
    end

    // Burst reads from the counter, plain reads from the pins
    assign raddr = burst_q ? pos_q[19:1] : double_word_address_bus; // RQ3

    always_comb begin
        b0.valid = read_sel;
        b0.last = burst_q && last_beat;
        b0.half = burst_q ? pos_q[0] : (half_word_select && !word_mode); // RQ1 RQ2
        b0.ident = high_voltage_id_address_line; // RQ14
        // Id select follows the array address, so burst id reads ignore later pin changes
        b0.id_dev = raddr[0]; // RQ14
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pipe1_q <= '0;
        end else begin
            pipe1_q <= b0;
        end
    end

    always_comb begin
        if (pipe1_q.ident) begin
            rd_mux = pipe1_q.id_dev ? DEVICE_ID : MAKER_ID; // RQ14
        end else if (word_mode) begin
            rd_mux = rdata; // RQ4
        end else begin
            rd_mux = {16'h0000, pipe1_q.half ? rdata[31:16] : rdata[15:0]}; // RQ1
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dq_o_q <= '0;
        end else begin
            dq_o_q <= rd_mux;
        end
    end

    // Per-lane enables; upper half stays off in x16 mode
    for (genvar i = 0; i < 32; i++) begin : g_lane
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                dq_oe_q[i] <= 1'b0;
            end else begin
                dq_oe_q[i] <= pipe1_q.valid && read_sel && (i < 16 || word_mode); // RQ4 RQ15
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            last_n_q <= 1'b1;
            wait_n_q <= 1'b1;
        end else begin
            last_n_q <= !(pipe1_q.valid && pipe1_q.last && read_sel && !cont); // RQ8
            wait_n_q <= (cont && burst_q) ? (pipe1_q.valid && read_sel) : 1'b1; // RQ9
        end
    end

    // Embedded program sequencer
    assign fifo_out_ready = state_q == flash_pin_pkg::st_idle && hw_reset_n;
    assign pop = fifo_out_valid && fifo_out_ready;
    assign prot_hit = !write_protect_n && prog_addr_q >= `PROT_BASE; // RQ10
    assign mem_we = state_q == flash_pin_pkg::st_prog && cnt_q == 12'h001 && hw_reset_n;

    always_comb begin
        state_d = state_q;
        if (!hw_reset_n) begin
            state_d = flash_pin_pkg::st_hwrst; // RQ12
        end else begin
            unique case (state_q)
                flash_pin_pkg::st_idle: if (pop && !prot_hit) state_d = flash_pin_pkg::st_prog; // RQ10
                flash_pin_pkg::st_prog: if (cnt_q == 12'h001) state_d = flash_pin_pkg::st_idle;
                flash_pin_pkg::st_hwrst: if (cnt_q == 12'h001) state_d = flash_pin_pkg::st_idle;
                default: state_d = flash_pin_pkg::st_idle;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= flash_pin_pkg::st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else if (!hw_reset_n) begin
            cnt_q <= 12'(`HWRST_CYC); // RQ12
        end else if (pop && !prot_hit) begin
            cnt_q <= program_accelerate_input ? 12'(`ACC_PROG_CYC) : 12'(`PROG_CYC); // RQ13
        end else if (cnt_q != 12'h000) begin
            cnt_q <= cnt_q - 12'h001;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pdata_q <= '0;
        end else if (pop) begin
            pdata_q <= fifo_out_data;
        end
    end

    // Ready/busy: open drain, pull low whenever not idle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rb_oe_q <= 1'b0;
            rb_o_q <= 1'b0;
        end else begin
            rb_oe_q <= state_d != flash_pin_pkg::st_idle; // RQ11 RQ12
            rb_o_q <= 1'b0;
        end
    end

    // Register bus slave
    assign acc = hsel && htrans[1] && hready;
    assign wr_done = dph_q && hready && dwr_q;
    assign fifo_in_valid = dph_q && dwr_q && dofs_q == `OFS_PDATA && !hreadyout_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            dph_q <= 1'b0;
            dwr_q <= 1'b0;
            dofs_q <= '0;
        end else if (acc) begin
            dph_q <= 1'b1;
            dwr_q <= hwrite;
            dofs_q <= haddr[7:0];
        end else if (hready) begin
            dph_q <= 1'b0;
        end
    end

    // Data writes wait for room; a full FIFO stalls the bus
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout_q <= 1'b1;
        end else if (acc && hwrite && haddr[7:0] == `OFS_PDATA) begin
            hreadyout_q <= 1'b0;
        end else if (fifo_in_valid && fifo_in_ready) begin
            hreadyout_q <= 1'b1;
        end
    end

    always_comb begin
        status = '0;
        status[`ST_BUSY] = state_q != flash_pin_pkg::st_idle;
        status[`ST_REFUSED] = refused_q;
        status[`ST_ACCEL] = program_accelerate_input;
        status[`ST_IDSEL] = high_voltage_id_address_line;
        status[`ST_EMPTY] = !fifo_out_valid;
        status[`ST_FULL] = !fifo_in_ready;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_q <= '0;
            hresp_q <= 1'b0;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                `OFS_CTRL: hrdata_q <= {30'h00000000, len_q};
                `OFS_PADDR: hrdata_q <= {13'h0000, prog_addr_q};
                `OFS_STATUS: hrdata_q <= status;
                default: hrdata_q <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            len_q <= `CTRL_LEN_RST;
        end else if (wr_done && dofs_q == `OFS_CTRL) begin
            len_q <= hwdata[1:0];
        end
    end

    // Software write of the address wins over the post-program increment
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prog_addr_q <= '0;
        end else if (wr_done && dofs_q == `OFS_PADDR) begin
            prog_addr_q <= hwdata[18:0];
        end else if (mem_we) begin
            prog_addr_q <= prog_addr_q + 19'h00001;
        end
    end

    // Refusal is sticky; a new refusal beats a write-one clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            refused_q <= 1'b0;
        end else if (pop && prot_hit) begin
            refused_q <= 1'b1; // RQ10
        end else if (wr_done && dofs_q == `OFS_STATUS && hwdata[`ST_REFUSED]) begin
            refused_q <= 1'b0;
        end
    end

    prog_fifo #(.W(32), .D(`FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(hwdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Single clock domain, shared with the host if desired
    flash_array #(.AW(19), .DW(32)) u_array (
        .mclk(mclk), // RQ6
        .we(mem_we),
        .waddr(prog_addr_q),
        .wdata(pdata_q),
        .raddr(raddr),
        .rdata_q(rdata)
    );

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign bidirectional_data_lines_o = dq_o_q;
    assign bidirectional_data_lines_oe = dq_oe_q;
    assign burst_last_word_n = last_n_q;
    assign wait_n = wait_n_q;
    assign ready_busy_n_o = rb_o_q;
    assign ready_busy_n_oe = rb_oe_q;

    sequence s_prog_start;
        state_q == flash_pin_pkg::st_idle && pop && !prot_hit && hw_reset_n
            ##1 state_q == flash_pin_pkg::st_prog;
    endsequence

    property p_upper_off;
        @(posedge mclk) disable iff (!arst_n) !word_mode |=> bidirectional_data_lines_oe[31:16] == 16'h0000;
    endproperty
    a_upper_off: assert property (p_upper_off) else $error("upper lanes driven in x16"); // RQ15

    property p_full_width;
        @(posedge mclk) disable iff (!arst_n)
            (word_mode && read_sel && pipe1_q.valid) |=> bidirectional_data_lines_oe == 32'hFFFFFFFF;
    endproperty
    a_full_width: assert property (p_full_width) else $error("x32 read not on all lanes"); // RQ4

    property p_busy_prog;
        @(posedge mclk) disable iff (!arst_n) s_prog_start |-> ready_busy_n_oe [*8];
    endproperty
    a_busy_prog: assert property (p_busy_prog) else $error("busy not held in program"); // RQ12

    property p_busy_reset;
        @(posedge mclk) disable iff (!arst_n) !hw_reset_n |=> ready_busy_n_oe && !ready_busy_n_o;
    endproperty
    a_busy_reset: assert property (p_busy_reset) else $error("busy not shown in reset"); // RQ12

    property p_release;
        @(posedge mclk) disable iff (!arst_n) (mem_we && hw_reset_n) |=> !ready_busy_n_oe;
    endproperty
    a_release: assert property (p_release) else $error("ready not released"); // RQ11

    property p_accel;
        @(posedge mclk) disable iff (!arst_n)
            (state_q == flash_pin_pkg::st_idle && pop && !prot_hit && program_accelerate_input)
            |-> ##[ACC_N:ACC_N] state_q != flash_pin_pkg::st_prog;
    endproperty
    a_accel: assert property (p_accel) else $error("accelerated program time wrong"); // RQ13

    property p_normal;
        @(posedge mclk) disable iff (!arst_n)
            (state_q == flash_pin_pkg::st_idle && pop && !prot_hit && !program_accelerate_input && hw_reset_n)
            |-> ##[PROG_N:PROG_N] state_q != flash_pin_pkg::st_prog;
    endproperty
    a_normal: assert property (p_normal) else $error("program time wrong"); // RQ13

    property p_protect;
        @(posedge mclk) disable iff (!arst_n) (pop && prot_hit) |=> refused_q && !mem_we && !ready_busy_n_oe;
    endproperty
    a_protect: assert property (p_protect) else $error("protected program not refused"); // RQ10

    property p_load;
        @(posedge mclk) disable iff (!arst_n) load |=> pos_q == $past(start_unit) && burst_q;
    endproperty
    a_load: assert property (p_load) else $error("burst start not captured"); // RQ7

    property p_advance;
        @(posedge mclk) disable iff (!arst_n)
            (advance && cont && !chip_enable_n) |=> pos_q == $past(pos_q) + $past(step);
    endproperty
    a_advance: assert property (p_advance) else $error("burst address did not step"); // RQ16

    property p_last;
        @(posedge mclk) disable iff (!arst_n) !burst_last_word_n |-> $past(!cont && pipe1_q.last);
    endproperty
    a_last: assert property (p_last) else $error("last-word indicator misplaced"); // RQ8

    property p_wait;
        @(posedge mclk) disable iff (!arst_n) !cont |=> wait_n;
    endproperty
    a_wait: assert property (p_wait) else $error("wait driven outside continuous"); // RQ9
endmodule

// ### pin_host_model.sv
`timescale 1ns/1ps
module pin_host_model (
    input wire logic mclk,
    input wire logic [31:0] dq_o,
    input wire logic [31:0] dq_oe,
    input wire logic rb_o,
    input wire logic rb_oe,
    output logic ce_n,
    output logic oe_n,
    output logic load_n,
    output logic [18:0] addr,
    output logic half,
    output logic [31:0] dq,
    output logic rb
);
    logic [31:0] dq_last_q = 32'h00000000;
    initial begin
        ce_n = 1'h1;
        oe_n = 1'h1;
        load_n = 1'h1;
        addr = 19'h0;
        half = 1'h0;
    end
    always_ff @(posedge mclk) begin
        dq_last_q <= dq;
    end
    // Released lanes flip, so a stale value never passes as data
    assign dq = (dq_o & dq_oe) | (~dq_last_q & ~dq_oe);
    assign rb = rb_oe ? rb_o : 1'h1;
    task automatic start(input logic [18:0] a, input logic h);
        @(posedge mclk);
        ce_n <= 1'h0;
        load_n <= 1'h0;
        addr <= a;
        half <= h;
        @(posedge mclk);
        load_n <= 1'h1;
        oe_n <= 1'h0;
        addr <= ~a;
        half <= ~h;
    endtask
    task automatic stop;
        @(posedge mclk);
        ce_n <= 1'h1;
        oe_n <= 1'h1;
    endtask
endmodule

// ### burst_flash_pin_interface_tb.sv
`timescale 1ns/1ps
`include "flash_pin_map.svh"
module burst_flash_pin_interface_tb;
    logic mclk = 1'h0;
    logic arst_n = 1'h0;
    logic [31:0] haddr, hwdata, hrdata, data_o, data_oe, dq, rd;
    logic [1:0] htrans;
    logic hwrite, hreadyout, hresp, hw_reset_n, word_mode, wp_n, accel, idv;
    logic last_n, wait_n, rb_o, rb_oe, rb, ce_n, oe_n, load_n, half;
    logic [18:0] addr;
    int miscompares = 0;
    int checked = 0;
    always #4 mclk = ~mclk;
    initial begin
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hw_reset_n = 1'h1;
        word_mode = 1'h1;
        wp_n = 1'h1;
        accel = 1'h0;
        idv = 1'h0;
    end
    // Id values arbitrary
    burst_flash_pin_interface #(.MAKER_ID(32'h00000011), .DEVICE_ID(32'h00000022)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(1'h1),
        .hw_reset_n(hw_reset_n), .word_mode(word_mode), .write_protect_n(wp_n),
        .program_accelerate_input(accel), .high_voltage_id_address_line(idv),
        .double_word_address_bus(addr), .half_word_select(half), .burst_address_load_n(load_n),
        .bidirectional_data_lines_i(dq), .bidirectional_data_lines_o(data_o),
        .bidirectional_data_lines_oe(data_oe), .burst_last_word_n(last_n), .wait_n(wait_n),
        .ready_busy_n_i(rb), .ready_busy_n_o(rb_o), .ready_busy_n_oe(rb_oe));
    pin_host_model host (.mclk(mclk), .dq_o(data_o), .dq_oe(data_oe), .rb_o(rb_o), .rb_oe(rb_oe),
        .ce_n(ce_n), .oe_n(oe_n), .load_n(load_n), .addr(addr), .half(half), .dq(dq), .rb(rb));
    task automatic tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wait_hr;
        int i;
        i = 0;
        @(posedge mclk);
        while (hreadyout !== 1'h1 && i < 3000) begin
            i++;
            @(posedge mclk);
        end
        if (i >= 3000) miscompares++;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_hr;
        htrans <= 2'h0;
        hwdata <= d;
        wait_hr;
        r = hrdata;
    endtask
    task automatic idle_wait;
        int i;
        i = 0;
        do begin
            ahb(1'h0, `OFS_STATUS, 32'h0, rd);
            i++;
        end while ((rd[`ST_BUSY] || !rd[`ST_EMPTY]) && i < 6000);
        if (rd[`ST_BUSY] || !rd[`ST_EMPTY]) miscompares++;
    endtask
    task automatic burst(input logic [18:0] a, input logic h, input int n, input logic [1:0] l);
        logic [19:0] p, q, m;
        logic [31:0] w;
        int s;
        s = word_mode ? 2 : 1;
        p = word_mode ? {a, 1'h0} : {a, h};
        // Continuous: mask of all ones, so no wrap
        m = (l == 2'h0) ? 20'hFFFFF : 20'(n * s - 1);
        host.start(a, h);
        @(posedge mclk);
        #1;
        chk("wait0", {31'h0, l != 2'h0}, {31'h0, wait_n});
        for (int k = 0; k < n; k++) begin
            @(posedge mclk);
            #1;
            q = (p & ~m) | ((p + 20'(k * s)) & m);
            w = 32'hA5000000 + 32'(q[19:1] - 19'h20);
            if (word_mode) chk("dq32", w, dq);
            else chk("dq16", {16'h0, q[0] ? w[31:16] : w[15:0]}, {16'h0, dq[15:0]});
            chk("oe", word_mode ? 32'hFFFFFFFF : 32'h0000FFFF, data_oe);
            chk("last", {31'h0, !(l != 2'h0 && k == n - 1)}, {31'h0, last_n});
            chk("wait", 32'h1, {31'h0, wait_n});
        end
        host.stop;
    endtask
    task automatic pin_one(input logic [18:0] a, input logic [31:0] e);
        host.start(a, 1'h0);
        repeat (2) @(posedge mclk);
        #1;
        chk("pin", e, dq);
        host.stop;
    endtask
    initial begin
        #(40000 * 8);
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'h1;
        #1;
        chk("rst", 32'h7, {29'h0, hreadyout, last_n, wait_n});
        chk("rst_rb", 32'h0, {31'h0, rb_oe});
        ahb(1'h0, 8'h40, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        ahb(1'h1, `OFS_PADDR, 32'h20, rd);
        // One spare push past full, so the FIFO must stall the bus
        for (int i = 0; i < 34; i++) begin
            ahb(1'h1, `OFS_PDATA, 32'hA5000000 + 32'(i), rd);
            if (i == 32) begin
                chk("rb_busy", 32'h0, {31'h0, rb});
                ahb(1'h0, `OFS_STATUS, 32'h0, rd);
                chk("full", 32'h1, {31'h0, rd[`ST_FULL]});
            end
        end
        idle_wait;
        chk("rb_idle", 32'h0, {31'h0, rb_oe});
        ahb(1'h0, `OFS_PADDR, 32'h0, rd);
        chk("paddr", 32'h42, rd);
        for (int l = 0; l < 4; l++) begin
            ahb(1'h1, `OFS_CTRL, 32'(l), rd);
            burst(19'h23, 1'h1, (l == 0) ? 5 : (l == 1) ? 4 : (l == 2) ? 8 : 32, 2'(l));
        end
        word_mode <= 1'h0;
        ahb(1'h1, `OFS_CTRL, 32'h2, rd);
        burst(19'h21, 1'h1, 8, 2'h2);
        word_mode <= 1'h1;
        wp_n <= 1'h0;
        ahb(1'h1, `OFS_PADDR, 32'h7F000, rd);
        ahb(1'h1, `OFS_PDATA, 32'h5A5A1234, rd);
        idle_wait;
        chk("refused", 32'h1, {31'h0, rd[`ST_REFUSED]});
        ahb(1'h1, `OFS_STATUS, 32'h2, rd);
        wp_n <= 1'h1;
        accel <= 1'h1;
        ahb(1'h1, `OFS_PDATA, 32'h5A5A1234, rd);
        ahb(1'h0, `OFS_STATUS, 32'h0, rd);
        chk("accel", 32'h1, {31'h0, rd[`ST_ACCEL]});
        repeat (90) @(posedge mclk);
        // Slow program takes 250 cycles; accelerated one must be done by now
        chk("acc_done", 32'h0, {31'h0, rb_oe});
        idle_wait;
        chk("unrefused", 32'h0, {31'h0, rd[`ST_REFUSED]});
        pin_one(19'h7F000, 32'h5A5A1234);
        accel <= 1'h0;
        idv <= 1'h1;
        pin_one(19'h0, 32'h00000011);
        pin_one(19'h1, 32'h00000022);
        idv <= 1'h0;
        @(posedge mclk);
        hw_reset_n <= 1'h0;
        repeat (2) @(posedge mclk);
        hw_reset_n <= 1'h1;
        #1;
        chk("hwrst_rb", 32'h1, {31'h0, rb_oe});
        repeat (55) @(posedge mclk);
        #1;
        chk("hwrst_hold", 32'h1, {31'h0, rb_oe});
        repeat (15) @(posedge mclk);
        #1;
        chk("hwrst_end", 32'h0, {31'h0, rb_oe});
        tally_and_finish;
    end
endmodule
